// ---- include/clk_cfg_pkg.sv ----
// Package with register map, field layout, reset values and timing of the clock path configuration block.
package clk_cfg_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W  = 10;

  // ==========================================================================
  // Register indices; the byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_PLL_CTRL = 10'h010;
  localparam logic [IDX_W-1:0] IDX_VCO_CAL  = 10'h018;
  localparam logic [IDX_W-1:0] IDX_REF_EN   = 10'h01C;
  localparam logic [IDX_W-1:0] IDX_VCO_DIV  = 10'h1E0;
  localparam logic [IDX_W-1:0] IDX_SRC_SEL  = 10'h1E1;
  localparam logic [IDX_W-1:0] IDX_UPDATE   = 10'h232;
  localparam logic [IDX_W-1:0] IDX_NVM_CTRL = 10'h240;

  // ==========================================================================
  // Field positions
  localparam int PLL_PWR_LSB   = 0;
  localparam int PFD_POL_BIT   = 7;
  localparam int CAL_BIT       = 0;
  localparam int CAL_BUSY_BIT  = 1;
  localparam int REF_EN_LSB    = 0;
  localparam int DIV_SEL_LSB   = 0;
  localparam int BYPASS_BIT    = 0;
  localparam int SRC_BIT       = 1;
  localparam int UPDATE_BIT    = 0;
  localparam int NVM_SAVE_BIT  = 0;
  localparam int NVM_BUSY_BIT  = 0;
  localparam int NVM_VALID_BIT = 1;

  // ==========================================================================
  // Field encodings
  localparam logic [1:0] PWR_NORMAL   = 2'h0;
  localparam logic [1:0] PWR_ASYNC_PD = 2'h1;

  typedef struct packed {
    logic       pfd_neg;
    logic [1:0] pll_power;
    logic       cal;
    logic [2:0] ref_en;
    logic [2:0] div_sel;
    logic       src_vco;
    logic       div_bypass;
  } cfg_type;

  localparam int CFG_W = $bits(cfg_type);

  // ==========================================================================
  // Values after reset
  localparam cfg_type CFG_RESET = '{
    pfd_neg:    1'h0,
    pll_power:  PWR_ASYNC_PD,
    cal:        1'h0,
    ref_en:     3'h0,
    div_sel:    3'h0,
    src_vco:    1'h0,
    div_bypass: 1'h0
  };

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int CAL_TIME_NS   = 800;
  localparam int CAL_CYCLES    = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================================
  // Nonvolatile image layout
  localparam int NVM_DW    = 16;
  localparam int NVM_AW    = 1;
  localparam int NVM_DEPTH = 2;
  localparam logic [NVM_AW-1:0] NVM_CFG_SLOT = 1'h0;
  localparam logic [NVM_AW-1:0] NVM_SIG_SLOT = 1'h1;
  // Arbitrary marker value that tags a valid stored image.
  localparam logic [NVM_DW-1:0] NVM_SIGNATURE = 16'hA5C3;

  // ==========================================================================
  // Enumerations
  typedef enum logic [2:0] {
    SEL_NONE     = 3'h0,
    SEL_PLL_CTRL = 3'h1,
    SEL_VCO_CAL  = 3'h2,
    SEL_REF_EN   = 3'h3,
    SEL_VCO_DIV  = 3'h4,
    SEL_SRC_SEL  = 3'h5,
    SEL_UPDATE   = 3'h6,
    SEL_NVM_CTRL = 3'h7
  } reg_sel_type;

  typedef enum logic [2:0] {
    NVM_LOAD_CFG = 3'h0,
    NVM_LOAD_SIG = 3'h1,
    NVM_LOAD_END = 3'h2,
    NVM_IDLE     = 3'h3,
    NVM_SAVE_CFG = 3'h4,
    NVM_SAVE_SIG = 3'h5
  } nvm_state_type;

endpackage

// ---- include/nvm_port_if.sv ----
// Interface between the configuration logic and the nonvolatile image store.
`timescale 1ns/1ns
interface nvm_port_if;
  import clk_cfg_pkg::*;
  logic              wr_en;
  logic [NVM_AW-1:0] addr;
  logic [NVM_DW-1:0] wdata;
  logic [NVM_DW-1:0] rdata;
  modport ctrl  (output wr_en, output addr, output wdata, input rdata);
  modport store (input wr_en, input addr, input wdata, output rdata);
endinterface

// ---- src/config_store.sv ----
// Nonvolatile configuration image store with registered read port.
`timescale 1ns/1ns
module config_store (
  input wire logic   mclk,
  input wire logic   rst_b,
  nvm_port_if.store  nvm
);
  import clk_cfg_pkg::*;

  typedef struct packed {
    logic [NVM_DW-1:0] rdata;
  } state_type;

  state_type         st_reg;
  state_type         st_next;
  logic [NVM_DW-1:0] mem [NVM_DEPTH];

  // ==========================================================================
  // Storage; the array is not cleared by reset so the image survives it.
  always_ff @(posedge mclk) begin
    if (nvm.wr_en) begin
      mem[nvm.addr] <= nvm.wdata;
    end
  end

  // ==========================================================================
  // Read port
  always_comb begin
    st_next       = st_reg;
    st_next.rdata = mem[nvm.addr];
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign nvm.rdata = st_reg.rdata;
endmodule

// ---- src/clock_path_mode_config.sv ----
// Clock source path mode configuration with APB registers, update strobe, calibration and image restore.
`timescale 1ns/1ns

// Contract
// - Power field 00 runs PLL, 01 powers down
// - Source bit 1 picks VCO, 0 external clock
// - Bypass bit 0 uses divider, 1 bypasses
// - Three bits enable reference inputs individually
// - Polarity bit 0 positive, 1 negative
// - Calibrate bit plus update strobe starts calibration
// - Configuration saved nonvolatile, restored at power-up
// - Reset: PLL down, divide by 2, clock
// - Divider ratios one to six by field
module clock_path_mode_config #(
  parameter int CAL_CYCLES = clk_cfg_pkg::CAL_CYCLES
) (
  input  wire logic                       mclk,
  input  wire logic                       rst_b,
  input  wire logic [clk_cfg_pkg::ADDR_W-1:0] paddr,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [clk_cfg_pkg::DATA_W-1:0] pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic      [clk_cfg_pkg::DATA_W-1:0] prdata,
  output logic                            pready,
  output logic                            pslverr,
  output logic                            pll_enable,
  output logic                            pll_power_down,
  output logic      [1:0]                 pll_power_mode,
  output logic                            pfd_negative,
  output logic      [2:0]                 ref_enable,
  output logic                            src_vco_select,
  output logic                            vco_div_bypass,
  output logic      [2:0]                 vco_div_code,
  output logic      [2:0]                 vco_div_ratio,
  output logic                            vco_cal_start,
  output logic                            vco_cal_busy
);
  import clk_cfg_pkg::*;

  // ==========================================================================
  // Parameter checks
  if (CAL_CYCLES < 1 || CAL_CYCLES > 65535) begin : g_bad_cal
    $error("CAL_CYCLES must lie between 1 and 65535.");
  end
  if (CFG_W > NVM_DW) begin : g_bad_image
    $error("The configuration image must fit one store word.");
  end

  // ==========================================================================
  // State
  typedef struct packed {
    cfg_type           stg;
    cfg_type           act;
    cfg_type           ld;
    logic              cal_busy;
    logic [15:0]       cal_cnt;
    logic              cal_start;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    nvm_state_type     nvm_state;
    logic              nvm_valid;
    logic              nvm_wr;
    logic [NVM_AW-1:0] nvm_addr;
    logic [NVM_DW-1:0] nvm_wdata;
    logic              pll_on;
    logic              pll_pd;
    logic [2:0]        ratio;
  } state_type;

  localparam logic [15:0] CAL_LAST = 16'(CAL_CYCLES - 1);

  state_type   st_reg;
  state_type   st_next;
  reg_sel_type setup_sel;
  reg_sel_type access_sel;
  logic        wr_fire;
  logic        update_fire;
  logic        save_fire;
  logic [7:0]  wbyte;

  // ==========================================================================
  // Image store.
  nvm_port_if nvm ();

  config_store u_store (
    .mclk  (mclk),
    .rst_b (rst_b),
    .nvm   (nvm)
  );

  // ==========================================================================
  // Helper functions
  function automatic reg_sel_type addr_to_sel(input logic [ADDR_W-1:0] a);
    logic [IDX_W-1:0] idx;
    idx = a[ADDR_W-1:2];
    if (a[1:0] != 2'h0) begin
      return SEL_NONE;
    end
    case (idx)
      IDX_PLL_CTRL: return SEL_PLL_CTRL;
      IDX_VCO_CAL:  return SEL_VCO_CAL;
      IDX_REF_EN:   return SEL_REF_EN;
      IDX_VCO_DIV:  return SEL_VCO_DIV;
      IDX_SRC_SEL:  return SEL_SRC_SEL;
      IDX_UPDATE:   return SEL_UPDATE;
      IDX_NVM_CTRL: return SEL_NVM_CTRL;
      default:      return SEL_NONE;
    endcase
  endfunction

  // ==========================================================================
  // Divider code to ratio.
  function automatic logic [2:0] div_ratio(input logic [2:0] code);
    case (code)
      3'h0:    return 3'h2;
      3'h1:    return 3'h3;
      3'h2:    return 3'h4;
      3'h3:    return 3'h5;
      3'h4:    return 3'h6;
      default: return 3'h1;
    endcase
  endfunction

  // ==========================================================================
  // Power field to power-down and enable flags.
  function automatic logic [1:0] power_flags(input logic [1:0] field);
    logic [1:0] f;
    f = 2'h0;
    case (field)
      PWR_NORMAL:   f = 2'h1;
      PWR_ASYNC_PD: f = 2'h2;
      default:      f = 2'h0;
    endcase
    return f;
  endfunction

  // ==========================================================================
  // Read value of a register.
  function automatic logic [7:0] read_byte(input reg_sel_type sel, input state_type s);
    logic [7:0] v;
    v = 8'h00;
    case (sel)
      SEL_PLL_CTRL: begin
        v[PLL_PWR_LSB +: 2] = s.stg.pll_power;
        v[PFD_POL_BIT]      = s.stg.pfd_neg;
      end
      SEL_VCO_CAL: begin
        v[CAL_BIT]      = s.stg.cal;
        v[CAL_BUSY_BIT] = s.cal_busy;
      end
      SEL_REF_EN: begin
        v[REF_EN_LSB +: 3] = s.stg.ref_en;
      end
      SEL_VCO_DIV: begin
        v[DIV_SEL_LSB +: 3] = s.stg.div_sel;
      end
      SEL_SRC_SEL: begin
        v[BYPASS_BIT] = s.stg.div_bypass;
        v[SRC_BIT]    = s.stg.src_vco;
      end
      SEL_NVM_CTRL: begin
        v[NVM_BUSY_BIT]  = (s.nvm_state != NVM_IDLE);
        v[NVM_VALID_BIT] = s.nvm_valid;
      end
      SEL_UPDATE:   v = 8'h00;
      default:      v = 8'h00;
    endcase
    return v;
  endfunction

  // ==========================================================================
  // Bus decode
  assign setup_sel   = addr_to_sel(paddr);
  assign access_sel  = addr_to_sel(paddr);
  assign wbyte       = pwdata[7:0];
  assign wr_fire     = psel
    && penable
    && st_reg.pready
    && pwrite
    && pstrb[0]
    && (access_sel != SEL_NONE);
  assign update_fire = wr_fire
    && (access_sel == SEL_UPDATE)
    && wbyte[UPDATE_BIT];
  assign save_fire   = wr_fire
    && (access_sel == SEL_NVM_CTRL)
    && wbyte[NVM_SAVE_BIT];

  // ==========================================================================
  // Next state
  always_comb begin
    st_next           = st_reg;
    st_next.cal_start = 1'b0;
    st_next.nvm_wr    = 1'b0;

    // ====================================
    // APB answer: one wait-free access phase, held off while the image engine runs.
    st_next.pready  = psel
      && !st_reg.pready
      && (st_reg.nvm_state == NVM_IDLE);
    st_next.pslverr = 1'b0;
    if (psel && !st_reg.pready) begin
      st_next.prdata  = {24'h000000, read_byte(setup_sel, st_reg)};
      st_next.pslverr = st_next.pready && (setup_sel == SEL_NONE);
    end

    // ====================================
    // Staging writes.
    if (wr_fire) begin
      case (access_sel)
        SEL_PLL_CTRL: begin
          st_next.stg.pll_power = wbyte[PLL_PWR_LSB +: 2];
          st_next.stg.pfd_neg   = wbyte[PFD_POL_BIT];
        end
        SEL_VCO_CAL: begin
          st_next.stg.cal = wbyte[CAL_BIT];
        end
        SEL_REF_EN: begin
          st_next.stg.ref_en = wbyte[REF_EN_LSB +: 3];
        end
        SEL_VCO_DIV: begin
          st_next.stg.div_sel = wbyte[DIV_SEL_LSB +: 3];
        end
        SEL_SRC_SEL: begin
          st_next.stg.src_vco    = wbyte[SRC_BIT];
          st_next.stg.div_bypass = wbyte[BYPASS_BIT];
        end
        default: st_next.stg = st_next.stg;
      endcase
    end

    // ====================================
    // Update strobe copies staging into the live configuration.
    if (update_fire) begin
      st_next.act = st_reg.stg;
    end

    // ====================================
    // Image save and restore engine.
    case (st_reg.nvm_state)
      NVM_LOAD_CFG: begin
        st_next.nvm_addr  = NVM_SIG_SLOT;
        st_next.nvm_state = NVM_LOAD_SIG;
      end
      NVM_LOAD_SIG: begin
        st_next.ld        = nvm.rdata[CFG_W-1:0];
        st_next.nvm_state = NVM_LOAD_END;
      end
      NVM_LOAD_END: begin
        if (nvm.rdata == NVM_SIGNATURE) begin
          st_next.stg       = st_reg.ld;
          st_next.act       = st_reg.ld;
          st_next.nvm_valid = 1'b1;
        end
        st_next.nvm_state = NVM_IDLE;
      end
      NVM_IDLE: begin
        if (save_fire) begin
          st_next.nvm_wr    = 1'b1;
          st_next.nvm_addr  = NVM_CFG_SLOT;
          st_next.nvm_wdata = {{(NVM_DW-CFG_W){1'b0}}, st_reg.stg};
          st_next.nvm_state = NVM_SAVE_CFG;
        end
      end
      NVM_SAVE_CFG: begin
        st_next.nvm_wr    = 1'b1;
        st_next.nvm_addr  = NVM_SIG_SLOT;
        st_next.nvm_wdata = NVM_SIGNATURE;
        st_next.nvm_state = NVM_SAVE_SIG;
      end
      NVM_SAVE_SIG: begin
        st_next.nvm_addr  = NVM_CFG_SLOT;
        st_next.nvm_valid = 1'b1;
        st_next.nvm_state = NVM_IDLE;
      end
      default: st_next.nvm_state = NVM_IDLE;
    endcase

    // ====================================
    // Calibration runs only on a rising edge of the live calibrate bit.
    if (st_reg.cal_busy) begin
      if (st_reg.cal_cnt == 16'h0000) begin
        st_next.cal_busy = 1'b0;
      end else begin
        st_next.cal_cnt = st_reg.cal_cnt - 16'h0001;
      end
    end
    if (st_next.act.cal && !st_reg.act.cal) begin
      st_next.cal_start = 1'b1;
      st_next.cal_busy  = 1'b1;
      st_next.cal_cnt   = CAL_LAST;
    end

    // ====================================
    // Decoded path controls.
    {st_next.pll_pd, st_next.pll_on} = power_flags(st_next.act.pll_power);
    st_next.ratio                    = div_ratio(st_next.act.div_sel);
  end

  // ==========================================================================
  // State register
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_reg           <= '0;
      st_reg.stg       <= CFG_RESET;
      st_reg.act       <= CFG_RESET;
      st_reg.ld        <= CFG_RESET;
      st_reg.nvm_state <= NVM_LOAD_CFG;
      st_reg.nvm_addr  <= NVM_CFG_SLOT;
      {st_reg.pll_pd, st_reg.pll_on} <= power_flags(CFG_RESET.pll_power);
      st_reg.ratio                   <= div_ratio(CFG_RESET.div_sel);
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign nvm.wr_en      = st_reg.nvm_wr;
  assign nvm.addr       = st_reg.nvm_addr;
  assign nvm.wdata      = st_reg.nvm_wdata;

  // ==========================================================================
  // Block outputs.
  assign prdata         = st_reg.prdata;
  assign pready         = st_reg.pready;
  assign pslverr        = st_reg.pslverr;
  assign pll_enable     = st_reg.pll_on;
  assign pll_power_down = st_reg.pll_pd;
  assign pll_power_mode = st_reg.act.pll_power;
  assign pfd_negative   = st_reg.act.pfd_neg;
  assign ref_enable     = st_reg.act.ref_en;
  assign src_vco_select = st_reg.act.src_vco;
  assign vco_div_bypass = st_reg.act.div_bypass;
  assign vco_div_code   = st_reg.act.div_sel;
  assign vco_div_ratio  = st_reg.ratio;
  assign vco_cal_start  = st_reg.cal_start;
  assign vco_cal_busy   = st_reg.cal_busy;
endmodule

// ---- test/clock_path_mode_config_chk.sv ----
// Assertions on the ports of the clock path mode configuration block.
`timescale 1ns/1ns
module clock_path_mode_config_chk #(
  parameter int CAL_CYCLES = 4
) (
  input wire logic                         mclk,
  input wire logic                         rst_b,
  input wire logic [clk_cfg_pkg::ADDR_W-1:0] paddr,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [clk_cfg_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0]                   pstrb,
  input wire logic                         pready,
  input wire logic                         pslverr,
  input wire logic                         pll_enable,
  input wire logic                         pll_power_down,
  input wire logic [1:0]                   pll_power_mode,
  input wire logic                         pfd_negative,
  input wire logic [2:0]                   ref_enable,
  input wire logic                         src_vco_select,
  input wire logic                         vco_div_bypass,
  input wire logic [2:0]                   vco_div_code,
  input wire logic [2:0]                   vco_div_ratio,
  input wire logic                         vco_cal_start,
  input wire logic                         vco_cal_busy
);
  import clk_cfg_pkg::*;
  // =====
  // Helper state: window after an update or reset, length of a busy run.
  typedef struct packed {
    logic [2:0] recent;
    logic [7:0] run;
  } chk_state_type;
  chk_state_type s_reg;
  chk_state_type s_next;
  logic          hit;
  assign hit = psel && penable && pready && pwrite && pstrb[0] && pwdata[UPDATE_BIT] && paddr == {IDX_UPDATE, 2'b00};
  always_comb begin
    s_next = s_reg;
    if (!rst_b) s_next.recent = 3'h6;
    else if (hit) s_next.recent = 3'h3;
    else if (s_reg.recent != 3'h0) s_next.recent = s_reg.recent - 3'h1;
    if (!rst_b) s_next.run = 8'h00;
    else if (vco_cal_start) s_next.run = 8'h01;
    else if (vco_cal_busy) s_next.run = s_reg.run + 8'h01;
    else s_next.run = 8'h00;
  end
  always_ff @(posedge mclk) begin
    s_reg <= s_next;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // =====
  // Properties.
  a_pll_enable_decode: assert property (pll_enable == (pll_power_mode == PWR_NORMAL))
    else $error("pll enable does not follow power field");
  a_power_down_decode: assert property (pll_power_down == (pll_power_mode == PWR_ASYNC_PD))
    else $error("power down does not follow power field");
  a_ratio_decode: assert property (vco_div_ratio == ((vco_div_code < 3'h5) ? vco_div_code + 3'h2 : 3'h1))
    else $error("divider ratio wrong for code");
  a_reset_defaults: assert property ($rose(rst_b) |-> pll_power_mode == PWR_ASYNC_PD && !src_vco_select
    && !vco_div_bypass && vco_div_code == 3'h0) else $error("outputs not at reset defaults");
  a_live_on_update: assert property (!$stable({pll_power_mode, pfd_negative, ref_enable, src_vco_select,
    vco_div_bypass, vco_div_code}) |-> s_reg.recent != 3'h0) else $error("live output moved without update");
  a_start_one_pulse: assert property (vco_cal_start |-> vco_cal_busy ##1 !vco_cal_start)
    else $error("calibration start not a single pulse with busy");
  a_start_has_cause: assert property (vco_cal_start |-> s_reg.recent != 3'h0)
    else $error("calibration started without update");
  a_busy_run_length: assert property ($fell(vco_cal_busy) |-> s_reg.run == 8'(CAL_CYCLES))
    else $error("calibration busy length wrong");
  a_ready_single: assert property (pready |-> psel && penable ##1 !pready)
    else $error("ready outside access or longer than one cycle");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("slave error without ready");
  a_ready_bound: assert property (psel && !penable |-> ##[1:6] pready)
    else $error("no ready after setup");
  cover property (vco_cal_start);
  cover property (hit);
  cover property (pslverr);
  cover property (pll_enable);
endmodule

bind clock_path_mode_config clock_path_mode_config_chk #(.CAL_CYCLES(CAL_CYCLES)) chk_inst (
  .mclk(mclk), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .pll_enable(pll_enable),
  .pll_power_down(pll_power_down), .pll_power_mode(pll_power_mode), .pfd_negative(pfd_negative),
  .ref_enable(ref_enable), .src_vco_select(src_vco_select), .vco_div_bypass(vco_div_bypass),
  .vco_div_code(vco_div_code), .vco_div_ratio(vco_div_ratio), .vco_cal_start(vco_cal_start),
  .vco_cal_busy(vco_cal_busy));

// ---- test/clock_path_mode_config_tb.sv ----
// Self-checking testbench for the clock path mode configuration block.
`timescale 1ns/1ns
module clock_path_mode_config_tb;
  import clk_cfg_pkg::*;
  localparam int CALN = 8;
  logic        mclk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdat, x, seed = 32'h412C11CB;
  logic [3:0]  pstrb = '0;
  logic        pready, pslverr, pll_enable, pll_power_down, pfd_negative, src_vco_select, vco_div_bypass;
  logic        vco_cal_start, vco_cal_busy, rerr, e_pol, e_src, e_byp;
  logic [1:0]  pll_power_mode, e_pwr;
  logic [2:0]  ref_enable, vco_div_code, vco_div_ratio, e_ref, e_div;
  int          n_fail = 0, n_compared = 0, n_start = 0, run = 0, busy_len = 0;

  clock_path_mode_config #(.CAL_CYCLES(CALN)) clock_path_mode_config_inst (
    .mclk(mclk), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pll_enable(pll_enable), .pll_power_down(pll_power_down), .pll_power_mode(pll_power_mode),
    .pfd_negative(pfd_negative), .ref_enable(ref_enable), .src_vco_select(src_vco_select),
    .vco_div_bypass(vco_div_bypass), .vco_div_code(vco_div_code), .vco_div_ratio(vco_div_ratio),
    .vco_cal_start(vco_cal_start), .vco_cal_busy(vco_cal_busy));

  always #4 mclk = ~mclk;

  always @(posedge mclk) begin
    if (vco_cal_start === 1'b1) n_start++;
    if (vco_cal_busy === 1'b1) run++;
    else if (run != 0) begin
      busy_len = run;
      run = 0;
    end
  end

  // =====
  // Helpers.
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [2:0] ratio(input logic [2:0] c);
    return (c < 3'h5) ? c + 3'h2 : 3'h1;
  endfunction

  task automatic give_verdict();
    if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] wd, input logic [3:0] st);
    int n;
    logic [31:0] r;
    n = 0;
    r = xs();
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {r[23:0], wd};
    pstrb   <= st;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge mclk);
    end
    if (n == 20) n_fail++;
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [IDX_W-1:0] i, input logic [7:0] v);
    bus(1'b1, {i, 2'b00}, v, 4'hF);
  endtask

  task automatic rdr(input logic [IDX_W-1:0] i);
    bus(1'b0, {i, 2'b00}, 8'h00, 4'hF);
  endtask

  task automatic strobe();
    wr(IDX_UPDATE, 8'h01);
    repeat (3) @(posedge mclk);
  endtask

  task automatic stage(input logic [1:0] p, input logic pol, input logic [2:0] r, input logic [2:0] d,
                       input logic s, input logic b, input logic c);
    logic [IDX_W-1:0] ix [5];
    logic [7:0]       v [5];
    ix = '{IDX_PLL_CTRL, IDX_REF_EN, IDX_VCO_DIV, IDX_SRC_SEL, IDX_VCO_CAL};
    v  = '{{pol, 5'h00, p}, {5'h00, r}, {5'h00, d}, {6'h00, s, b}, {7'h00, c}};
    foreach (ix[k]) wr(ix[k], v[k]);
    foreach (ix[k]) begin
      rdr(ix[k]);
      chk("staged_reg", rdat, 32'(v[k]));
    end
  endtask

  task automatic check_live();
    chk("power_mode", 32'(pll_power_mode), 32'(e_pwr));
    chk("pll_enable", 32'(pll_enable), 32'(e_pwr == 2'h0));
    chk("power_down", 32'(pll_power_down), 32'(e_pwr == 2'h1));
    chk("polarity", 32'(pfd_negative), 32'(e_pol));
    chk("ref_enable", 32'(ref_enable), 32'(e_ref));
    chk("source", 32'(src_vco_select), 32'(e_src));
    chk("bypass", 32'(vco_div_bypass), 32'(e_byp));
    chk("div_code", 32'(vco_div_code), 32'(e_div));
    chk("div_ratio", 32'(vco_div_ratio), 32'(ratio(e_div)));
  endtask

  // =====
  // Main sequence.
  initial begin
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (6) @(posedge mclk);
    {e_pwr, e_pol, e_ref, e_div, e_src, e_byp} = {2'h1, 9'h000};
    check_live();
    rdr(IDX_PLL_CTRL);
    chk("pll_ctrl_reset", rdat, 32'h01);
    rdr(IDX_SRC_SEL);
    chk("src_sel_reset", rdat, 32'h00);
    bus(1'b1, {IDX_PLL_CTRL, 2'b00}, 8'h80, 4'hE);
    rdr(IDX_PLL_CTRL);
    chk("masked_write", rdat, 32'h01);
    bus(1'b1, {IDX_PLL_CTRL, 2'b01}, 8'h80, 4'hF);
    chk("misaligned_err", 32'(rerr), 32'h1);
    rdr(10'h011);
    chk("unmapped_err", 32'(rerr), 32'h1);
    chk("unmapped_data", rdat, 32'h0);
    for (int i = 0; i < 16; i++) begin
      x = xs();
      stage(i[1:0], x[0], x[3:1], i[2:0], x[4], x[5], 1'b0);
      check_live();
      strobe();
      {e_pwr, e_pol, e_ref, e_div, e_src, e_byp} = {i[1:0], x[0], x[3:1], i[2:0], x[4], x[5]};
      check_live();
    end
    stage(2'h0, 1'b0, 3'h1, 3'h2, 1'b1, 1'b0, 1'b1);
    n_start = 0;
    strobe();
    {e_pwr, e_pol, e_ref, e_div, e_src, e_byp} = {2'h0, 1'b0, 3'h1, 3'h2, 1'b1, 1'b0};
    check_live();
    rdr(IDX_VCO_CAL);
    chk("cal_busy_bit", rdat, 32'h03);
    repeat (20) @(posedge mclk);
    chk("cal_starts", 32'(n_start), 32'h1);
    chk("cal_busy_len", 32'(busy_len), 32'(CALN));
    strobe();
    repeat (12) @(posedge mclk);
    chk("cal_no_restart", 32'(n_start), 32'h1);
    wr(IDX_VCO_CAL, 8'h00);
    strobe();
    wr(IDX_VCO_CAL, 8'h01);
    strobe();
    repeat (12) @(posedge mclk);
    chk("cal_restart", 32'(n_start), 32'h2);
    wr(IDX_NVM_CTRL, 8'h01);
    repeat (5) @(posedge mclk);
    rdr(IDX_NVM_CTRL);
    chk("image_valid", rdat, 32'h2);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (6) @(posedge mclk);
    check_live();
    rdr(IDX_REF_EN);
    chk("restored_stage", rdat, 32'h1);
    give_verdict();
  end

  initial begin
    #100000;
    n_fail++;
    give_verdict();
  end
endmodule
